//--- hw/pcp_compare.sv
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module pcp_compare #(
    parameter int ARRAY_DEPTH = 256
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic resetn,
    // Position sources.
    input wire pcp_pkg::pcp_axes_t axes,
    // Compare pulse and capture chain.
    output logic compare_pulse_out,
    output logic capture_enable_pulse,
    // AXI4-Lite write address.
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address.
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import pcp_pkg::*;

    localparam int AW = $clog2(ARRAY_DEPTH);

    // ==========================================================
    // Storage and control state.
    logic signed [31:0] data_array [ARRAY_DEPTH]; // Compare value list.
    logic [3:0] compare_control; // Enable, continuous, capture, polarity.
    logic [15:0] compare_array_start; // First index of the list.
    logic [15:0] compare_count; // Remaining compares.
    logic [15:0] count_load; // Count seen at enable, used for wrap.
    pcp_src_t compare_source_select; // Selected axis.
    logic [15:0] pulse_width; // Pulse width in clocks.
    logic [15:0] dout_function_cfg; // Digital output function setting.
    logic [15:0] index; // Current array index.
    logic signed [31:0] prev_pos; // Previous sampled position.
    logic prev_valid; // Previous sample is meaningful.
    logic [15:0] pulse_timer; // Remaining active pulse clocks.
    logic [31:0] event_total; // Events since reset, for status.

    // Byte-lane merge for a 32-bit write.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = nw[8*i +: 8];
            end
        end
        return r;
    endfunction

    // ==========================================================
    // Write channel: accept address and data in either order.
    logic aw_held, w_held;
    logic [11:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_fire = aw_held && w_held && !s_axi_bvalid;
    wire wr_array = aw_addr[11];
    wire [AW-1:0] wr_idx = aw_addr[AW+1:2];
    // The word index is widened by one bit so that a depth of 512 still fits the bound.
    wire wr_ok = wr_array ? ({1'b0, aw_addr[10:2]} < 10'(ARRAY_DEPTH)) :
                 (aw_addr <= PCP_ADDR_STATUS);
    wire wr_ctl = wr_fire && aw_addr == PCP_ADDR_CONTROL;

    // Address and data holding registers; response once both are in.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 12'h000;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= PCP_RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (w_take) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? PCP_RESP_OKAY : PCP_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_held;
    assign s_axi_wready = !w_held;

    // Array writes; no reset, the list is plain memory.
    always_ff @(posedge sys_clk) begin
        if (wr_fire && wr_array && wr_ok) begin
            data_array[wr_idx] <= merge(data_array[wr_idx], w_data, w_strb);
        end
    end

    // ==========================================================
    // Compare engine.
    logic signed [31:0] cur_pos;
    // Source multiplexer over the four axes.
    always_comb begin
        unique case (compare_source_select)
            PCP_SRC_MOTOR: cur_pos = axes.motor;
            PCP_SRC_LINEAR: cur_pos = axes.linear;
            PCP_SRC_PULSE: cur_pos = axes.pulse;
            PCP_SRC_CAPTURE: cur_pos = axes.capture;
        endcase
    end

    wire running = compare_control[PCP_CTL_ENABLE] && compare_count != 16'h0000;
    wire [AW-1:0] rd_idx = index[AW-1:0];
    // Current compare value as a signed pulse count.
    wire signed [31:0] target = data_array[rd_idx];
    // A crossing in either direction, or landing exactly on the value.
    wire crossed = prev_valid && (((prev_pos < target) && (cur_pos >= target)) ||
                                  ((prev_pos > target) && (cur_pos <= target)));
    wire hit = running && crossed;
    wire last_hit = hit && compare_count == 16'h0001;
    wire wrap = last_hit && compare_control[PCP_CTL_CONT];
    wire ctl_written = wr_ctl && w_strb[0];
    wire [3:0] ctl_new = w_data[3:0];
    // Enable with a zero count never runs.
    wire start_ok = ctl_written && ctl_new[PCP_CTL_ENABLE] && compare_count != 16'h0000;

    // Sequencer: start, advance, finish or wrap.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            compare_control <= 4'h0;
            compare_array_start <= 16'h0000;
            compare_count <= 16'h0000;
            count_load <= 16'h0000;
            compare_source_select <= PCP_SRC_MOTOR;
            pulse_width <= PCP_WIDTH_DEFAULT;
            dout_function_cfg <= PCP_DOUT_DEFAULT;
            index <= 16'h0000;
            prev_valid <= 1'b0;
            prev_pos <= 32'sh00000000;
            event_total <= 32'h00000000;
        end else begin
            prev_pos <= cur_pos;
            prev_valid <= running;
            if (ctl_written) begin
                compare_control <= ctl_new;
                compare_control[PCP_CTL_ENABLE] <= start_ok;
                if (start_ok) begin
                    index <= compare_array_start;
                    count_load <= compare_count;
                    prev_valid <= 1'b0;
                    dout_function_cfg <= PCP_DOUT_FORCED;
                end
            end else if (hit) begin
                event_total <= event_total + 32'h00000001;
                if (wrap) begin
                    compare_count <= count_load;
                    index <= compare_array_start;
                end else begin
                    compare_count <= compare_count - 16'h0001;
                    index <= index + 16'h0001;
                    if (last_hit) begin
                        compare_control[PCP_CTL_ENABLE] <= 1'b0;
                    end
                end
            end
            if (wr_fire && !hit) begin
                unique case (aw_addr)
                    PCP_ADDR_START: compare_array_start <= w_data[15:0];
                    PCP_ADDR_COUNT: compare_count <= w_data[15:0];
                    PCP_ADDR_SOURCE: compare_source_select <= pcp_src_t'(w_data[1:0]);
                    PCP_ADDR_WIDTH: pulse_width <= w_data[15:0];
                    PCP_ADDR_DOUT_CFG: dout_function_cfg <= w_data[15:0];
                    default: ;
                endcase
            end
        end
    end

    // Pulse generator: one pulse per event, pin always owned by compare.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pulse_timer <= 16'h0000;
            compare_pulse_out <= 1'b0;
            capture_enable_pulse <= 1'b0;
        end else begin
            if (hit) begin
                pulse_timer <= (pulse_width == 16'h0000) ? 16'h0001 : pulse_width;
            end else if (pulse_timer != 16'h0000) begin
                pulse_timer <= pulse_timer - 16'h0001;
            end
            // Output follows the hit one clock later, far inside the bound.
            compare_pulse_out <= (hit || pulse_timer > 16'h0001) ^
                                 compare_control[PCP_CTL_POLARITY];
            capture_enable_pulse <= last_hit && compare_control[PCP_CTL_CAPTURE];
        end
    end

    // ==========================================================
    // Read channel.
    logic [31:0] rd_word;
    wire rd_arr = s_axi_araddr[11];
    wire rd_ok = rd_arr ? ({1'b0, s_axi_araddr[10:2]} < 10'(ARRAY_DEPTH)) :
                 (s_axi_araddr <= PCP_ADDR_STATUS);
    wire [AW-1:0] ra_idx = s_axi_araddr[AW+1:2];
    // Read multiplexer; unmapped reads return zero.
    always_comb begin
        rd_word = 32'h00000000;
        if (rd_arr && rd_ok) begin
            rd_word = data_array[ra_idx];
        end else begin
            unique case (s_axi_araddr)
                PCP_ADDR_CONTROL: rd_word = {28'h0000000, compare_control};
                PCP_ADDR_START: rd_word = {16'h0000, compare_array_start};
                PCP_ADDR_COUNT: rd_word = {16'h0000, compare_count};
                PCP_ADDR_SOURCE: rd_word = {30'h00000000, compare_source_select};
                PCP_ADDR_WIDTH: rd_word = {16'h0000, pulse_width};
                PCP_ADDR_DOUT_CFG: rd_word = {16'h0000, dout_function_cfg};
                PCP_ADDR_STATUS: rd_word = event_total;
                default: rd_word = 32'h00000000;
            endcase
        end
    end

    // Read response register.
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= PCP_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? PCP_RESP_OKAY : PCP_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
    assign s_axi_arready = !s_axi_rvalid;

endmodule
`default_nettype wire

//--- inc/pcp_pkg.sv
package pcp_pkg;

    // ==========================================================
    // Register map, byte addresses.
    localparam logic [11:0] PCP_ADDR_CONTROL = 12'h000;
    localparam logic [11:0] PCP_ADDR_START = 12'h004;
    localparam logic [11:0] PCP_ADDR_COUNT = 12'h008;
    localparam logic [11:0] PCP_ADDR_SOURCE = 12'h00C;
    localparam logic [11:0] PCP_ADDR_WIDTH = 12'h010;
    localparam logic [11:0] PCP_ADDR_DOUT_CFG = 12'h014;
    localparam logic [11:0] PCP_ADDR_STATUS = 12'h018;
    localparam logic [11:0] PCP_ADDR_ARRAY = 12'h800;

    // ==========================================================
    // Control field positions.
    localparam int PCP_CTL_ENABLE = 0;
    localparam int PCP_CTL_CONT = 1;
    localparam int PCP_CTL_CAPTURE = 2;
    localparam int PCP_CTL_POLARITY = 3;

    // ==========================================================
    // Reset and forced values.
    localparam logic [15:0] PCP_DOUT_DEFAULT = 16'h0000;
    localparam logic [15:0] PCP_DOUT_FORCED = 16'h0100;
    localparam logic [15:0] PCP_WIDTH_DEFAULT = 16'h0014;

    // ==========================================================
    // Timing: the response bound and its cycle count at 20 MHz.
    localparam int PCP_RESP_NS = 5000;
    localparam int PCP_CLK_NS = 50;
    localparam int PCP_RESP_CYCLES = PCP_RESP_NS / PCP_CLK_NS;

    // Source axis selection codes.
    typedef enum logic [1:0] {
        PCP_SRC_MOTOR,
        PCP_SRC_LINEAR,
        PCP_SRC_PULSE,
        PCP_SRC_CAPTURE
    } pcp_src_t;

    // AXI4-Lite responses.
    localparam logic [1:0] PCP_RESP_OKAY = 2'h0;
    localparam logic [1:0] PCP_RESP_SLVERR = 2'h2;

    // The four position inputs travel together.
    typedef struct packed {
        logic signed [31:0] motor;
        logic signed [31:0] linear;
        logic signed [31:0] pulse;
        logic signed [31:0] capture;
    } pcp_axes_t;

endpackage

//--- tb/pcp_compare_properties.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// Handshake and pulse checks on the compare block's ports.
module pcp_compare_properties (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic resetn,
    // Watched ports.
    input wire logic capture_enable_pulse,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("Write response dropped.");
    property p_bdrop; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
    a_bdrop: assert property (p_bdrop) else $error("Write response repeated.");
    property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("Read data changed early.");
    property p_arrdy; s_axi_arready != s_axi_rvalid; endproperty
    a_arrdy: assert property (p_arrdy) else $error("Read address ready wrong.");
    // Both items are held first, the response follows at the edge after.
    property p_wresp; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
    a_wresp: assert property (p_wresp) else $error("Write response late.");
    property p_rresp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rresp: assert property (p_rresp) else $error("Read data late.");
    property p_rcause; $rose(s_axi_rvalid) |-> $past(s_axi_arvalid) && $past(s_axi_arready); endproperty
    a_rcause: assert property (p_rcause) else $error("Read data without request.");
    property p_cap; capture_enable_pulse |=> !capture_enable_pulse; endproperty
    a_cap: assert property (p_cap) else $error("Capture pulse too long.");
endmodule
bind pcp_compare pcp_compare_properties u_props (
    .sys_clk(sys_clk), .resetn(resetn), .capture_enable_pulse(capture_enable_pulse),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);
`default_nettype wire

//--- tb/pcp_motion_model.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// Motion controller input: counts compare pulses and their widths.
module pcp_motion_model (
    // Clock and pin.
    input wire logic sys_clk,
    input wire logic pulse_pin,
    input wire logic active_low,
    // Pulse statistics.
    output int pulse_cnt,
    output int last_width
);
    int run = 0; // Cycles in the current active run.
    initial pulse_cnt = 0;
    // Each active run counts once; its length is kept when it ends.
    always @(posedge sys_clk) begin
        if (pulse_pin ^ active_low) begin
            if (run == 0) pulse_cnt <= pulse_cnt + 1;
            run <= run + 1;
        end else begin
            if (run != 0) last_width <= run;
            run <= 0;
        end
    end
endmodule
`default_nettype wire

//--- tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
// ==========
// Self-checking bench for the compare block.
module tb;
    import pcp_pkg::*;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    pcp_axes_t axes = '0;
    logic aw = 0, w = 0, br = 0, ar = 0, rr = 0, pol = 0;
    logic [11:0] awa = '0, ara = '0;
    logic [31:0] wd = '0, rdata, rd;
    logic [1:0] rresp, rs;
    logic pin, cap, awr, wr, bv, arr, rv;
    int pulse_cnt, last_width, cap_cnt = 0, error_cnt = 0, compares = 0;
    pcp_compare uut (
        .sys_clk(sys_clk), .resetn(resetn), .axes(axes),
        .compare_pulse_out(pin), .capture_enable_pulse(cap),
        .s_axi_awaddr(awa), .s_axi_awvalid(aw), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(w), .s_axi_wready(wr),
        .s_axi_bresp(), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(ar), .s_axi_arready(arr),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr)
    );
    pcp_motion_model u_ctl (
        .sys_clk(sys_clk), .pulse_pin(pin), .active_low(pol),
        .pulse_cnt(pulse_cnt), .last_width(last_width)
    );
    initial forever #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (cap) cap_cnt <= cap_cnt + 1;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("Compares %0d, mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Bus writes: each channel holds until its ready is seen at a rising edge.
    task automatic axw(input logic [11:0] a, input logic [31:0] d);
        logic bg;
        bg = 1'b0;
        @(posedge sys_clk);
        awa <= a;
        wd <= d;
        aw <= 1'b1;
        w <= 1'b1;
        br <= 1'b1;
        while (!bg) begin
            @(posedge sys_clk);
            if (aw && awr) aw <= 1'b0;
            if (w && wr) w <= 1'b0;
            bg = br && bv;
        end
        br <= 1'b0;
    endtask
    // Bus reads: data and response are taken at the edge where rvalid is seen.
    task automatic axr(input logic [11:0] a);
        logic rg;
        rg = 1'b0;
        @(posedge sys_clk);
        ara <= a;
        ar <= 1'b1;
        rr <= 1'b1;
        while (!rg) begin
            @(posedge sys_clk);
            if (ar && arr) ar <= 1'b0;
            rg = rr && rv;
            rd = rdata;
            rs = rresp;
        end
        rr <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        axr(a);
        chk(rd, e);
    endtask
    // Moves the chosen axis, scrambles the rest, counts pulses in the bound.
    task automatic step(input int s, input logic [31:0] v, input int e);
        int p0;
        int n;
        p0 = pulse_cnt;
        n = 0;
        for (int i = 0; i < 4; i++) axes[(3 - i) * 32 +: 32] <= (i == s) ? v : $urandom;
        while (pulse_cnt == p0 && n < PCP_RESP_CYCLES) begin
            @(negedge sys_clk);
            n++;
        end
        @(posedge sys_clk);
        chk(pulse_cnt - p0, e);
        repeat (30) @(posedge sys_clk);
    endtask
    initial begin
        int b, d, st;
        logic [31:0] c;
        void'($urandom(95431));
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        rdchk(PCP_ADDR_DOUT_CFG, 0);
        rdchk(PCP_ADDR_WIDTH, 32'h14);
        axr(12'h100);
        chk(rs, PCP_RESP_SLVERR);
        for (int s = 0; s < 4; s++) begin
            b = int'($urandom_range(2000)) - 1000;
            d = (s % 2) ? -1 : 1;
            st = s * 4 + 1;
            c = (s == 2) ? 9 : (s == 3) ? 5 : 1;
            step(s, b, 0);
            for (int k = 1; k < 4; k++) axw(PCP_ADDR_ARRAY + 12'(4 * (st + k - 1)), b + d * 10 * k);
            axw(PCP_ADDR_START, st);
            axw(PCP_ADDR_COUNT, 3);
            axw(PCP_ADDR_SOURCE, s);
            axw(PCP_ADDR_WIDTH, (s == 2) ? 3 : 20);
            axw(PCP_ADDR_CONTROL, c);
            pol <= c[3];
            rdchk(PCP_ADDR_DOUT_CFG, 32'h100);
            chk(pin, c[3]);
            step(s, b + d * 5, 0);
            for (int k = 1; k < 4; k++) step(s, b + d * (10 * k + 5), 1);
            chk(cap_cnt, (s == 3) ? 1 : 0);
            chk(last_width, (s == 2) ? 3 : 20);
            rdchk(PCP_ADDR_COUNT, 0);
            rdchk(PCP_ADDR_CONTROL, c & 32'hE);
            step(s, b + d * 45, 0);
        end
        step(0, 0, 0);
        axw(PCP_ADDR_ARRAY + 12'h040, 100);
        axw(PCP_ADDR_ARRAY + 12'h044, 200);
        axw(PCP_ADDR_START, 16);
        axw(PCP_ADDR_COUNT, 2);
        axw(PCP_ADDR_SOURCE, 0);
        axw(PCP_ADDR_CONTROL, 3);
        step(0, 150, 1);
        step(0, 250, 1);
        step(0, 50, 1);
        rdchk(PCP_ADDR_CONTROL, 3);
        axw(PCP_ADDR_CONTROL, 0);
        axw(PCP_ADDR_COUNT, 0);
        axw(PCP_ADDR_CONTROL, 1);
        rdchk(PCP_ADDR_CONTROL, 0);
        rdchk(PCP_ADDR_STATUS, 15);
        tally_and_finish();
    end
    // Watchdog well beyond the few thousand cycles the tests need.
    initial begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
